// ### inc/apdc_defines.svh
// Constants for the automatic power-down controller.
`ifndef APDC_DEFINES_SVH
`define APDC_DEFINES_SVH

// Idle counter width and the terminal count of idle clock periods.
`define APDC_CNT_W 4
`define APDC_IDLE_LIMIT 4'hF

// Field positions in power mode register zero.
`define APDC_PMR0_TURBO_OFF 3
`define APDC_PMR0_CLK_AND 4
`define APDC_PMR0_CLK_MCELL 5

// Field positions in power mode register two (control signal blocking).
`define APDC_PMR2_ADDR_LO 0
`define APDC_PMR2_CNTL0 2
`define APDC_PMR2_CNTL1 3
`define APDC_PMR2_CNTL2 4
`define APDC_PMR2_STROBE 5
`define APDC_PMR2_DBE 6

// Reset values of the power mode registers (turbo on, nothing blocked).
`define APDC_PMR0_RST 8'h00
`define APDC_PMR2_RST 8'h00

`endif

// ### inc/apdc_pkg.sv
// Types shared by the power-down controller files.
package apdc_pkg;

  // Power state of the device, one-hot.
  typedef enum logic [1:0] {
    APDC_RUN  = 2'b01,
    APDC_DOWN = 2'b10
  } apdc_state_t;

endpackage

// ### verilog/apdc_activity.sv
// Address strobe activity detector and idle period counter.
`timescale 1ns/100ps
`default_nettype none

`include "apdc_defines.svh"

module apdc_activity (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // Control.
  input wire logic unit_enable,
  input wire logic strobe_polarity,
  input wire logic strobe_level,
  input wire logic clk_tick,
  // Results.
  output logic strobe_active,
  output logic idle_done
);

  logic strobe_prev_r;
  logic [`APDC_CNT_W-1:0] idle_cnt_r;

  ////////////////////////////////////////////////////////////////////////
  // A change of the strobe level counts as pulsing activity.
  assign strobe_active = strobe_level ^ strobe_prev_r;

  // Previous strobe level for edge detection. It follows the pin through
  // reset too, so a strobe that rests high is not taken for activity on
  // the first cycle after release.
  always_ff @(posedge clock) begin
    strobe_prev_r <= strobe_level;
  end

  ////////////////////////////////////////////////////////////////////////
  // Idle counter advances once per input clock period while idle.
  // activity restarts count
  always_ff @(posedge clock) begin
    if (reset) begin
      idle_cnt_r <= 4'h0;
    end else if (!unit_enable || strobe_active) begin
      idle_cnt_r <= 4'h0;
    end else if (clk_tick && strobe_level == strobe_polarity && idle_cnt_r != `APDC_IDLE_LIMIT) begin
      idle_cnt_r <= idle_cnt_r + 4'h1;
    end
  end

  assign idle_done = unit_enable && (idle_cnt_r == `APDC_IDLE_LIMIT);

endmodule

`default_nettype wire

// ### verilog/apdc_controller.sv
// Automatic power-down controller with run-time power mode blocking bits.
`timescale 1ns/100ps
`default_nettype none

`include "apdc_defines.svh"


// The controller sits between the processor bus and the memories, the
// logic arrays and the ports. It watches the address strobe, counts idle
// periods of the slow input clock and, once the count runs out, isolates
// the memories, the ports and the bus inputs of the logic arrays. The array
// clocks keep running throughout; only the clock bits of register zero cut them.
// Address-out pins are undefined in power-down; they are held at zero,
// which is one legal choice and keeps them from toggling.
// The clock copies handed to the logic are sampled by the core clock, so
// they show the input clock one cycle late and only up to half the core
// rate. A faster input clock would need a real gated clock path instead.

module apdc_controller (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // Microcontroller bus inputs.
  input wire logic addr_strobe_in,
  input wire logic pld_clock_in,
  input wire logic chip_select_n,
  input wire logic [7:0] mcu_addr_lo,
  input wire logic [7:0] mcu_data,
  input wire logic [2:0] mcu_cntl,
  input wire logic mcu_dbe,
  // Configuration.
  input wire logic auto_powerdown_unit,
  input wire logic strobe_polarity,
  // Power mode register writes.
  input wire logic pmr0_wr,
  input wire logic pmr2_wr,
  input wire logic [7:0] pmr_wdata,
  // Port drive requests from port logic.
  input wire logic [7:0] addr_out_req,
  input wire logic [7:0] data_port_oe_req,
  input wire logic [7:0] periph_oe_req,
  // Status.
  output logic powerdown_flag,
  output logic [7:0] power_mode_reg_zero,
  output logic [7:0] power_mode_reg_two,
  output logic turbo_on,
  // Memory side.
  output logic mem_select,
  output logic [7:0] mem_addr_lo,
  output logic [7:0] mem_data,
  // Logic array side.
  output logic [7:0] pld_addr_lo,
  output logic [2:0] pld_cntl,
  output logic pld_strobe,
  output logic pld_dbe,
  output logic pld_clk_and,
  output logic pld_clk_mcell,
  // Port side.
  output logic [7:0] addr_out,
  output logic [7:0] data_port_oe,
  output logic [7:0] periph_oe
);

  apdc_pkg::apdc_state_t state_r;
  logic strobe_active;
  logic idle_done;
  logic clk_prev_r;
  logic clk_tick;
  logic [7:0] pmr0_r;
  logic [7:0] pmr2_r;
  logic down_nxt;
  apdc_pkg::apdc_state_t state_nxt;

  // Gates a bus signal off when its blocking bit or power-down is set.
  function automatic logic pass_bit(input logic sig, input logic blk, input logic pd);
    pass_bit = sig & ~blk & ~pd;
  endfunction

  // Gates a whole byte off; used for the byte-wide paths that power-down isolates.
  // Blocked lines are held at zero rather than left to follow the bus, so
  // nothing downstream toggles while the device sleeps.
  function automatic logic [7:0] gate_byte(input logic [7:0] v, input logic off);
    gate_byte = off ? 8'h00 : v;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Rising edges of the input clock give a one-cycle period tick.
  // counter sees clock always
  assign clk_tick = pld_clock_in & ~clk_prev_r;

  // Previous input clock level.
  always_ff @(posedge clock) begin
    if (reset) begin
      clk_prev_r <= 1'b0;
    end else begin
      clk_prev_r <= pld_clock_in;
    end
  end

  // Activity detector and idle counter.
  apdc_activity u_activity (
    .clock(clock),
    .reset(reset),
    .unit_enable(auto_powerdown_unit),
    .strobe_polarity(strobe_polarity),
    .strobe_level(addr_strobe_in),
    .clk_tick(clk_tick),
    .strobe_active(strobe_active),
    .idle_done(idle_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // Power state machine; exits take priority over entry.
  // Entry also waits for chip select to be high: a selected device is in
  // use even if the strobe has gone quiet, and entering would only be
  // undone again on the following cycle.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      apdc_pkg::APDC_RUN: begin
        if (idle_done && chip_select_n && !strobe_active) begin
          state_nxt = apdc_pkg::APDC_DOWN;
        end
      end
      apdc_pkg::APDC_DOWN: begin
        if (strobe_active || !chip_select_n || !auto_powerdown_unit) begin
          state_nxt = apdc_pkg::APDC_RUN;
        end
      end
      default: begin
        state_nxt = apdc_pkg::APDC_RUN;
      end
    endcase
  end

  // State register; reset forces normal operation.
  always_ff @(posedge clock) begin
    if (reset) begin
      state_r <= apdc_pkg::APDC_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Outputs are registered from the next state, so the flag and the
  // isolation of the buses change on the same edge as the state itself.
  assign down_nxt = (state_nxt == apdc_pkg::APDC_DOWN);

  ////////////////////////////////////////////////////////////////////////
  // Power mode registers written by the microcontroller at run time.
  // Writes take effect on the next edge; set the blocking bits before the
  // device sleeps, since power-down does not change them.
  // turbo resets on
  always_ff @(posedge clock) begin
    if (reset) begin
      pmr0_r <= `APDC_PMR0_RST;
    end else if (pmr0_wr) begin
      pmr0_r <= pmr_wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      pmr2_r <= `APDC_PMR2_RST;
    end else if (pmr2_wr) begin
      pmr2_r <= pmr_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Power-down flag, registered from the next state.
  // flag follows the state
  always_ff @(posedge clock) begin
    if (reset) begin
      powerdown_flag <= 1'b0;
    end else begin
      powerdown_flag <= down_nxt;
    end
  end

  // Register readback; a write shows on the port in the cycle after it.
  always_ff @(posedge clock) begin
    if (reset) begin
      power_mode_reg_zero <= `APDC_PMR0_RST;
      power_mode_reg_two <= `APDC_PMR2_RST;
    end else begin
      power_mode_reg_zero <= pmr0_wr ? pmr_wdata : pmr0_r;
      power_mode_reg_two <= pmr2_wr ? pmr_wdata : pmr2_r;
    end
  end

  // Turbo state, on out of reset. Power-down leaves it alone, so the
  // logic keeps whatever speed the processor chose before it slept.
  always_ff @(posedge clock) begin
    if (reset) begin
      turbo_on <= 1'b1;
    end else begin
      turbo_on <= pmr0_wr ? ~pmr_wdata[`APDC_PMR0_TURBO_OFF] : ~pmr0_r[`APDC_PMR0_TURBO_OFF];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Memory path: deselected and isolated in power-down, deselected by chip select.
  // A one-cycle output register adds latency; acceptable for a gating model.
  always_ff @(posedge clock) begin
    if (reset) begin
      mem_select <= 1'b0;
      mem_addr_lo <= 8'h00;
      mem_data <= 8'h00;
    end else begin
      mem_select <= !chip_select_n && !down_nxt;
      mem_addr_lo <= gate_byte(mcu_addr_lo, down_nxt);
      mem_data <= gate_byte(mcu_data, down_nxt);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Logic array inputs: power-down and the blocking bits gate each bus signal; the clocks are gated only by their register zero bits.
  // Chip select plays no part here, so logic keeps working while deselected.
  always_ff @(posedge clock) begin
    if (reset) begin
      pld_addr_lo <= 8'h00;
      pld_strobe <= 1'b0;
      pld_dbe <= 1'b0;
    end else begin
      pld_addr_lo <= gate_byte(mcu_addr_lo, down_nxt || pmr2_r[`APDC_PMR2_ADDR_LO]);
      pld_strobe <= pass_bit(addr_strobe_in, pmr2_r[`APDC_PMR2_STROBE], down_nxt);
      pld_dbe <= pass_bit(mcu_dbe, pmr2_r[`APDC_PMR2_DBE], down_nxt);
    end
  end

  // Control lines to the logic, one gate per line. The three blocking bits
  // sit next to each other in register two, so the bit index follows the
  // line index. Blocking the strobe here never reaches the idle counter.
  // each bit blocks its line
  for (genvar i = 0; i < 3; i++) begin : g_cntl
    always_ff @(posedge clock) begin
      if (reset) begin
        pld_cntl[i] <= 1'b0;
      end else begin
        pld_cntl[i] <= pass_bit(mcu_cntl[i], pmr2_r[`APDC_PMR2_CNTL0 + i], down_nxt);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      pld_clk_and <= 1'b0;
      pld_clk_mcell <= 1'b0;
    end else begin
      pld_clk_and <= pld_clock_in & ~pmr0_r[`APDC_PMR0_CLK_AND];
      pld_clk_mcell <= pld_clock_in & ~pmr0_r[`APDC_PMR0_CLK_MCELL];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Port behaviour: address out undefined (held at zero), data and peripheral off.
  // I/O and logic-output pins are not routed here, so they keep their levels.
  always_ff @(posedge clock) begin
    if (reset) begin
      addr_out <= 8'h00;
      data_port_oe <= 8'h00;
      periph_oe <= 8'h00;
    end else begin
      addr_out <= gate_byte(addr_out_req, down_nxt);
      data_port_oe <= gate_byte(data_port_oe_req, down_nxt);
      periph_oe <= gate_byte(periph_oe_req, down_nxt);
    end
  end

endmodule

`default_nettype wire

// ### tb/apdc_monitor.sv
// Assertion checker for the power-down controller ports.
`timescale 1ns/100ps
`default_nettype none
module apdc_monitor (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // Watched inputs.
  input wire logic addr_strobe_in,
  input wire logic chip_select_n,
  input wire logic auto_powerdown_unit,
  input wire logic strobe_polarity,
  input wire logic pmr0_wr,
  input wire logic pmr2_wr,
  input wire logic [7:0] pmr_wdata,
  // Watched outputs.
  input wire logic powerdown_flag,
  input wire logic [7:0] power_mode_reg_zero,
  input wire logic [7:0] power_mode_reg_two,
  input wire logic turbo_on,
  input wire logic mem_select,
  input wire logic [7:0] mem_data,
  input wire logic [7:0] data_port_oe,
  input wire logic pld_clk_and
);
  // One clock domain, so clock and reset are given once.
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  ////////////////////////////////
  // turbo readback.
  AST_TURBO: assert property (turbo_on == !power_mode_reg_zero[3])
    else $error("turbo state differs from bit three");
  AST_WR_ZERO: assert property (pmr0_wr |=> power_mode_reg_zero == $past(pmr_wdata))
    else $error("register zero write lost");
  AST_WR_TWO: assert property (pmr2_wr |=> power_mode_reg_two == $past(pmr_wdata))
    else $error("register two write lost");
  AST_ENTRY: assert property ($rose(powerdown_flag) |-> $past(auto_powerdown_unit) && $past(chip_select_n)
    && $past(addr_strobe_in) == $past(strobe_polarity)) else $error("entry without idle strobe");
  AST_CS_EXIT: assert property (!chip_select_n |=> !powerdown_flag)
    else $error("selected while down");
  AST_WAKE: assert property (powerdown_flag && $changed(addr_strobe_in) |-> ##[1:3] !powerdown_flag)
    else $error("strobe activity did not wake");
  AST_MEM_OFF: assert property (powerdown_flag && $past(powerdown_flag) |-> !mem_select && mem_data == 8'h00)
    else $error("memory reached while down");
  AST_TRISTATE: assert property (powerdown_flag && $past(powerdown_flag) |-> data_port_oe == 8'h00)
    else $error("data port driven while down");
  AST_CLK_CUT: assert property ($past(power_mode_reg_zero[4]) |-> !pld_clk_and)
    else $error("blocked clock reached logic");
  AST_DESEL: assert property (chip_select_n |=> !mem_select)
    else $error("memory selected while deselected");
  AST_UNIT_OFF: assert property (!auto_powerdown_unit |=> !powerdown_flag)
    else $error("down with unit disabled");
endmodule
`default_nettype wire

// ### tb/apdc_mcu_model.sv
// Processor-side model: address strobe activity and the slow input clock.
`timescale 1ns/100ps
`default_nettype none
module apdc_mcu_model (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // Activity control.
  input wire logic busy,
  input wire logic rest_level,
  // Pins and idle tick count.
  output logic addr_strobe_in = 1'b0,
  output logic pld_clock_in = 1'b0,
  output int idle_ticks = 0
);
  logic [2:0] div_r = 3'h0;
  logic stb_nxt;
  logic rise;
  // A busy processor toggles the strobe each cycle; idle, it rests.
  assign stb_nxt = busy ? ~addr_strobe_in : rest_level;
  assign rise = div_r[2] & ~pld_clock_in;
  // The input clock runs at an eighth of the core rate, so the short
  // reaction of the block never spans two ticks.
  always @(posedge clock) begin
    div_r <= reset ? 3'h0 : div_r + 3'h1;
    pld_clock_in <= ~reset & div_r[2];
    addr_strobe_in <= reset ? rest_level : stb_nxt;
    idle_ticks <= (reset || stb_nxt != addr_strobe_in) ? 0 : idle_ticks + int'(rise);
  end
endmodule
`default_nettype wire

// ### tb/apdc_controller_test.sv
// Self-checking bench for the power-down controller.
`timescale 1ns/100ps
`default_nettype none
module apdc_controller_test;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic chip_select_n = 1'b1;
  logic auto_powerdown_unit = 1'b1;
  logic strobe_polarity = 1'b0;
  logic busy = 1'b1;
  logic rest_level = 1'b0;
  logic pmr0_wr = 1'b0;
  logic pmr2_wr = 1'b0;
  logic [7:0] pmr_wdata = 8'h00;
  logic [31:0] bus_r = 32'h1;
  logic [31:0] wseed = 32'h1;
  logic was_down = 1'b0;
  logic [31:0] bus_q = 32'h0;
  logic clk_q = 1'b0;
  logic stb_q = 1'b0;
  logic pld_strobe, pld_dbe, pld_clk_mcell;
  logic [2:0] pld_cntl;
  logic [7:0] mem_addr_lo, pld_addr_lo, addr_out, periph_oe;
  logic addr_strobe_in, pld_clock_in, powerdown_flag, turbo_on, mem_select, pld_clk_and;
  logic [7:0] power_mode_reg_zero, power_mode_reg_two, mem_data, data_port_oe;
  int idle_ticks;
  int n_errors = 0;
  int checked = 0;
  int exp_q[$];
  apdc_mcu_model u_mcu (.clock, .reset, .busy, .rest_level, .addr_strobe_in, .pld_clock_in, .idle_ticks);
  apdc_controller u_dut (.clock, .reset, .addr_strobe_in, .pld_clock_in, .chip_select_n,
    .mcu_addr_lo(bus_r[7:0]), .mcu_data(bus_r[15:8]), .mcu_cntl(bus_r[18:16]), .mcu_dbe(bus_r[19]),
    .auto_powerdown_unit, .strobe_polarity, .pmr0_wr, .pmr2_wr, .pmr_wdata,
    .addr_out_req(bus_r[27:20]), .data_port_oe_req(bus_r[31:24]), .periph_oe_req(bus_r[23:16]),
    .powerdown_flag, .power_mode_reg_zero, .power_mode_reg_two, .turbo_on, .mem_select,
    .mem_addr_lo, .mem_data, .pld_addr_lo, .pld_cntl, .pld_strobe, .pld_dbe,
    .pld_clk_and, .pld_clk_mcell, .addr_out, .data_port_oe, .periph_oe);
  ////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s exp %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("mismatches %0d of %0d checks", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Bounded wait for the flag; running out ends the run as a failure.
  task automatic wait_flag(input logic v);
    for (int i = 0; i < 300 && powerdown_flag !== v; i++) @(posedge clock);
    if (powerdown_flag !== v) begin
      check("flag wait", {7'h00, powerdown_flag}, {7'h00, v});
      finish_test();
    end
  endtask
  task automatic wr_reg(input logic sel, input logic [7:0] v);
    @(posedge clock);
    pmr0_wr <= ~sel;
    pmr2_wr <= sel;
    pmr_wdata <= v;
    @(posedge clock);
    pmr0_wr <= 1'b0;
    pmr2_wr <= 1'b0;
    #1;
    check("reg", sel ? power_mode_reg_two : power_mode_reg_zero, v);
    if (!sel) check("turbo", {7'h00, turbo_on}, {7'h00, ~v[3]});
  endtask
  task automatic pulse;
    @(posedge clock) busy <= 1'b1;
    @(posedge clock) busy <= 1'b0;
  endtask
  ////////////////////////////////
  // Clock, and random bus traffic that the block must block or pass.
  initial forever #5 clock = ~clock;
  always @(posedge clock) bus_r <= xs(bus_r);
  // Inputs as the block sampled them one edge ago, for registered outputs.
  always @(posedge clock) begin
    bus_q <= bus_r;
    clk_q <= pld_clock_in;
    stb_q <= addr_strobe_in;
  end
  // Each entry is matched against the oldest noted tick count.
  always @(posedge clock) begin
    if (!reset && powerdown_flag === 1'b1 && !was_down) begin
      if (exp_q.size() == 0) check("unexpected entry", 8'h01, 8'h00);
      else check("idle ticks", idle_ticks[7:0], 8'(exp_q.pop_front()));
    end
    was_down = (powerdown_flag === 1'b1);
  end
  initial begin
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    #1;
    check("turbo reset", {7'h00, turbo_on}, 8'h01);
    check("reg zero reset", power_mode_reg_zero, 8'h00);
    for (int i = 0; i < 6; i++) begin
      wseed = xs(wseed);
      wr_reg(wseed[8], wseed[7:0]);
    end
    wr_reg(1'b0, 8'h00);
    $display("register test done");
    for (int p = 0; p < 2; p++) begin
      if (p == 1) wr_reg(1'b0, 8'h38);
      wr_reg(1'b1, p[0] ? 8'h7D : 8'h00);
      @(posedge clock);
      strobe_polarity <= p[0];
      rest_level <= p[0];
      @(posedge clock);
      exp_q.push_back(15);
      busy <= 1'b0;
      repeat (60) @(posedge clock);
      pulse();
      wait_flag(1'b1);
      #1;
      check("mem_select", {7'h00, mem_select}, 8'h00);
      check("mem_data", mem_data, 8'h00);
      check("data_port_oe", data_port_oe, 8'h00);
      check("pld_clk_and", {7'h00, pld_clk_and}, {7'h00, ~p[0] & clk_q});
      check("pld_clk_mcell", {7'h00, pld_clk_mcell}, {7'h00, ~p[0] & clk_q});
      check("mem_addr_lo", mem_addr_lo, 8'h00);
      check("pld_addr_lo", pld_addr_lo, 8'h00);
      check("pld_cntl", {5'h00, pld_cntl}, 8'h00);
      check("pld_strobe", {7'h00, pld_strobe}, 8'h00);
      check("pld_dbe", {7'h00, pld_dbe}, 8'h00);
      check("periph_oe", periph_oe, 8'h00);
      exp_q.push_back(15);
      pulse();
      wait_flag(1'b0);
      wait_flag(1'b1);
      chip_select_n <= 1'b0;
      busy <= 1'b1;
      wait_flag(1'b0);
      @(posedge clock);
      #1;
      check("selected", {7'h00, mem_select}, 8'h01);
      check("mem_addr_lo up", mem_addr_lo, bus_q[7:0]);
      check("mem_data up", mem_data, bus_q[15:8]);
      check("addr_out up", addr_out, bus_q[27:20]);
      check("data_port_oe up", data_port_oe, bus_q[31:24]);
      check("periph_oe up", periph_oe, bus_q[23:16]);
      check("pld_cntl up", {5'h00, pld_cntl}, p[0] ? 8'h00 : {5'h00, bus_q[18:16]});
      check("pld_dbe up", {7'h00, pld_dbe}, {7'h00, ~p[0] & bus_q[19]});
      check("pld_strobe up", {7'h00, pld_strobe}, {7'h00, ~p[0] & stb_q});
      @(posedge clock) chip_select_n <= 1'b1;
      @(posedge clock);
      #1;
      check("deselected", {7'h00, mem_select}, 8'h00);
      check("pld_addr_lo desel", pld_addr_lo, p[0] ? 8'h00 : bus_q[7:0]);
      $display("entry test done");
    end
    @(posedge clock);
    rest_level <= 1'b0;
    busy <= 1'b0;
    repeat (200) @(posedge clock);
    auto_powerdown_unit <= 1'b0;
    rest_level <= 1'b1;
    repeat (200) @(posedge clock);
    check("flag idle", {7'h00, powerdown_flag}, 8'h00);
    check("notes left", 8'(exp_q.size()), 8'h00);
    $display("no-count test done");
    finish_test();
  end
endmodule
bind apdc_controller apdc_monitor u_mon (.clock, .reset, .addr_strobe_in, .chip_select_n, .auto_powerdown_unit,
  .strobe_polarity, .pmr0_wr, .pmr2_wr, .pmr_wdata, .powerdown_flag, .power_mode_reg_zero,
  .power_mode_reg_two, .turbo_on, .mem_select, .mem_data, .data_port_oe, .pld_clk_and);
`default_nettype wire
